// *** sfec_defines.svh ***
// constants for the serial flash erase / power-down command interpreter
// assumes a 200 MHz core clock; all link pins are asynchronous to it
//
// Notes on behaviour
// - opcode 20h plus three address bytes erases the sector holding the address
// - opcode 52h plus three address bytes erases the 32 KB block holding it
// - opcode d8h plus three address bytes erases the 64 KB block holding it
// - opcode 60h or c7h alone erases the whole array
// - erase runs only when the write enable latch is set
// - offset bits inside the target region are ignored
// - addressed erase runs only if select rises right after the 32nd bit (opcode plus 24 address bits)
// - one-byte commands run only if select rises right after the eighth bit
// - erase starts at select rise; busy flag high throughout, low when done
// - write enable latch is cleared before the erase cycle ends
// - sector or block erase into a protected region is not executed
// - array erase only when protect bits all zero with cmp 0, or all one with cmp 1
// - after enable, serial output shows 0 while busy and 1 while ready
// - ready/busy disable stops the serial output showing status
// - opcode b9h enters deep power-down after a delay; the only way in
// - in deep power-down every command except release is ignored
// - deep power-down during an internal cycle is rejected, cycle undisturbed
// - deselect with no cycle running means standby, not deep power-down
// - power-up always lands in standby
// - opcode abh alone releases deep power-down; host waits the release time
`ifndef SFEC_DEFINES_SVH
`define SFEC_DEFINES_SVH

// ****************************************
// opcodes
// ****************************************
`define SFEC_OP_SECTOR_ERASE   8'h20
`define SFEC_OP_BLOCK32_ERASE  8'h52
`define SFEC_OP_BLOCK64_ERASE  8'hd8
`define SFEC_OP_ARRAY_ERASE_A  8'h60
`define SFEC_OP_ARRAY_ERASE_B  8'hc7
`define SFEC_OP_WRITE_ENABLE   8'h06
`define SFEC_OP_RDY_ENABLE     8'h70
`define SFEC_OP_RDY_DISABLE    8'h80
`define SFEC_OP_POWER_DOWN     8'hb9
`define SFEC_OP_RELEASE_PD     8'hab
`define SFEC_OP_RESET_ENABLE   8'h66
`define SFEC_OP_RESET          8'h99

// ****************************************
// bit counts and timing
// ****************************************
`define SFEC_OPCODE_BITS       6'd8
`define SFEC_ADDR_CMD_BITS     6'd32
`define SFEC_CLK_PERIOD_NS     5
`define SFEC_PD_ENTRY_NS       3000
`define SFEC_PD_RELEASE_NS     3000
`define SFEC_PD_ENTRY_CYC      ((`SFEC_PD_ENTRY_NS + `SFEC_CLK_PERIOD_NS - 1) / `SFEC_CLK_PERIOD_NS)
`define SFEC_PD_RELEASE_CYC    ((`SFEC_PD_RELEASE_NS + `SFEC_CLK_PERIOD_NS - 1) / `SFEC_CLK_PERIOD_NS)
`define SFEC_SECTOR_ERASE_CYC  20000
`define SFEC_ARRAY_ERASE_CYC   200000

`endif

// *** sfec_pkg.sv ***
// types for the serial flash erase / power-down command interpreter
// assumes sfec_defines.svh is included by the design that uses them
package sfec_pkg;

	// power state of the device
	typedef enum logic [1:0] {
		SFEC_STANDBY,
		SFEC_ERASING,
		SFEC_PD_ENTER,
		SFEC_PD_EXIT
	} sfec_mode_t;

	// kind of erase pending
	typedef enum logic [1:0] {
		SFEC_ER_SECTOR,
		SFEC_ER_BLK32,
		SFEC_ER_BLK64,
		SFEC_ER_ARRAY
	} sfec_erase_t;

endpackage

// *** sfec_cmd.sv ***
// command decoder: erase, ready/busy routing, deep power-down entry and release
// assumes cs, sck and si come from pins; protection bits come from the status logic
`timescale 1ns/1ps
`include "sfec_defines.svh"

module sfec_cmd #(
	parameter int SECTOR_ERASE_CYC = `SFEC_SECTOR_ERASE_CYC,
	parameter int ARRAY_ERASE_CYC  = `SFEC_ARRAY_ERASE_CYC
) (
	// clock and power-up reset
	input  wire logic                 clk_in,
	input  wire logic                 reset_in,
	// serial link pins
	input  wire logic                 cs_n_in,
	input  wire logic                 sck_in,
	input  wire logic                 si_in,
	output logic                      so_out,
	output logic                      so_oe_out,
	// protection settings and busy from other cycles
	input  wire logic [4:0]           block_protect_field_in,
	input  wire logic                 protect_complement_bit_in,
	input  wire logic                 other_cycle_busy_in,
	// status and erase request
	output logic                      write_enable_latch_out,
	output logic                      write_in_progress_flag_out,
	output logic                      deep_power_down_out,
	output logic                      erase_start_out,
	output sfec_pkg::sfec_erase_t     erase_kind_out,
	output logic [23:0]               erase_base_out
);
	import sfec_pkg::*;

	localparam int PD_ENTRY_CYC   = `SFEC_PD_ENTRY_CYC;
	localparam int PD_RELEASE_CYC = `SFEC_PD_RELEASE_CYC;

	// ****************************************
	// whole state
	// ****************************************
	typedef struct packed {
		logic [2:0]  cs_sync;
		logic [2:0]  sck_sync;
		logic [1:0]  si_sync;
		logic [5:0]  bit_count;
		logic [31:0] shift;
		logic        write_enable_latch;
		logic        rdy_route;
		logic        reset_armed;
		sfec_mode_t  mode;
		logic        pd;
		logic [17:0] timer;
		logic        start;
		sfec_erase_t kind;
		logic [23:0] base;
	} sfec_state_t;

	sfec_state_t state;
	sfec_state_t next_state;

	// protected-region test for a block index; simplistic top/bottom split by field
	function automatic logic sfec_protected(input logic [23:0] addr, input logic [4:0] bp,
			input logic cmp);
		logic [3:0] blk;
		logic       hit;
		logic [3:0] idx;
		blk = addr[19:16];
		if (bp[2:0] == 3'h0) begin
			hit = 1'b0;
		end else if (bp[2:0] == 3'h7) begin
			hit = 1'b1;
		end else begin
			// 1, 2, 4 ... 32 blocks counted from the top (bp3 low) or the bottom;
			// six bits wide so the all-blocks limit does not wrap to zero
			idx = bp[3] ? blk : ~blk;
			hit = {2'b00, idx} < (6'h01 << (bp[2:0] - 3'h1));
		end
		sfec_protected = hit ^ cmp;
	endfunction

	// region base: low offset bits dropped per erase size
	function automatic logic [23:0] sfec_base(input logic [23:0] addr, input sfec_erase_t k);
		unique case (k)
			SFEC_ER_SECTOR: sfec_base = {addr[23:12], 12'h000};
			SFEC_ER_BLK32:  sfec_base = {addr[23:15], 15'h0000};
			SFEC_ER_BLK64:  sfec_base = {addr[23:16], 16'h0000};
			SFEC_ER_ARRAY:  sfec_base = 24'h000000;
		endcase
	endfunction

	logic        sck_rise;
	logic        cs_rise;
	logic        cs_fall;
	logic [7:0]  opcode;
	logic [7:0]  op_now;
	logic [23:0] addr_now;
	logic        busy;

	assign sck_rise = state.sck_sync[1] & ~state.sck_sync[2];
	assign cs_rise  = state.cs_sync[1] & ~state.cs_sync[2];
	assign cs_fall  = ~state.cs_sync[1] & state.cs_sync[2];
	assign op_now   = state.shift[7:0];
	assign opcode   = state.shift[31:24];
	assign addr_now = state.shift[23:0];
	// any running cycle, local or elsewhere, blocks new work
	assign busy     = state.mode != SFEC_STANDBY || other_cycle_busy_in;

	// ****************************************
	// next-state logic
	// ****************************************
	always_comb begin
		next_state          = state;
		next_state.start    = 1'b0;
		// third flop only feeds the edge detectors
		next_state.cs_sync  = {state.cs_sync[1:0], cs_n_in};
		next_state.sck_sync = {state.sck_sync[1:0], sck_in};
		next_state.si_sync  = {state.si_sync[0], si_in};
		if (cs_fall) begin
			next_state.bit_count = 6'd0;
		end
		// msb-first shift on rising serial clock while selected
		if (sck_rise && !state.cs_sync[1]) begin
			next_state.shift = {state.shift[30:0], state.si_sync[1]};
			if (state.bit_count != 6'h3f) begin
				next_state.bit_count = state.bit_count + 6'd1;
			end
		end
		// commands act only at the deselect edge
		if (cs_rise) begin
			if (state.pd) begin
				// only release is heard in power-down
				if (state.bit_count == `SFEC_OPCODE_BITS && op_now == `SFEC_OP_RELEASE_PD &&
						state.mode == SFEC_STANDBY) begin
					next_state.mode  = SFEC_PD_EXIT;
					next_state.timer = 18'(PD_RELEASE_CYC);
				end
			end else if (state.bit_count == `SFEC_OPCODE_BITS) begin
				unique case (op_now)
					`SFEC_OP_WRITE_ENABLE: begin
						// refused mid-cycle so an erase cannot re-arm itself
						if (!busy) begin
							next_state.write_enable_latch = 1'b1;
						end
					end
					`SFEC_OP_RDY_ENABLE:  next_state.rdy_route = 1'b1;
					`SFEC_OP_RDY_DISABLE: next_state.rdy_route = 1'b0;
					`SFEC_OP_POWER_DOWN: begin
						// refused while any cycle runs
						if (!busy) begin
							next_state.mode  = SFEC_PD_ENTER;
							next_state.timer = 18'(PD_ENTRY_CYC);
						end
					end
					`SFEC_OP_ARRAY_ERASE_A, `SFEC_OP_ARRAY_ERASE_B: begin
						if (!busy && state.write_enable_latch &&
								((block_protect_field_in[2:0] == 3'h0 &&
								!protect_complement_bit_in) ||
								(block_protect_field_in[2:0] == 3'h7 &&
								protect_complement_bit_in))) begin
							next_state.mode  = SFEC_ERASING;
							next_state.kind  = SFEC_ER_ARRAY;
							next_state.base  = 24'h000000;
							next_state.timer = 18'(ARRAY_ERASE_CYC);
							next_state.start = 1'b1;
						end
					end
					`SFEC_OP_RESET_ENABLE: next_state.reset_armed = 1'b1;
					`SFEC_OP_RESET: begin
						if (state.reset_armed && !busy) begin
							next_state.write_enable_latch       = 1'b0;
							next_state.rdy_route = 1'b0;
						end
					end
					default: ;
				endcase
				if (op_now != `SFEC_OP_RESET_ENABLE) begin
					next_state.reset_armed = 1'b0;
				end
			end else if (state.bit_count == `SFEC_ADDR_CMD_BITS) begin
				next_state.reset_armed = 1'b0;
				if (!busy && state.write_enable_latch && (opcode == `SFEC_OP_SECTOR_ERASE ||
						opcode == `SFEC_OP_BLOCK32_ERASE ||
						opcode == `SFEC_OP_BLOCK64_ERASE)) begin
					next_state.kind = opcode == `SFEC_OP_SECTOR_ERASE ? SFEC_ER_SECTOR :
						opcode == `SFEC_OP_BLOCK32_ERASE ? SFEC_ER_BLK32 : SFEC_ER_BLK64;
					next_state.base = sfec_base(addr_now, next_state.kind);
					if (!sfec_protected(addr_now, block_protect_field_in,
							protect_complement_bit_in)) begin
						next_state.mode  = SFEC_ERASING;
						next_state.timer = 18'(SECTOR_ERASE_CYC);
						next_state.start = 1'b1;
					end
				end
			end else begin
				next_state.reset_armed = 1'b0; // other deselect points cancel
			end
		end
		// self-timed cycles
		unique case (state.mode)
			SFEC_STANDBY: ;
			SFEC_ERASING: begin
				next_state.write_enable_latch = 1'b0;
				if (state.timer <= 18'd1) begin
					next_state.mode = SFEC_STANDBY;
				end else begin
					next_state.timer = state.timer - 18'd1;
				end
			end
			SFEC_PD_ENTER: begin
				if (state.timer <= 18'd1) begin
					next_state.mode = SFEC_STANDBY;
					next_state.pd   = 1'b1;
				end else begin
					next_state.timer = state.timer - 18'd1;
				end
			end
			SFEC_PD_EXIT: begin
				if (state.timer <= 18'd1) begin
					next_state.mode = SFEC_STANDBY;
					next_state.pd   = 1'b0;
				end else begin
					next_state.timer = state.timer - 18'd1;
				end
			end
		endcase
	end

	// ****************************************
	// state register, power-up lands in standby
	// ****************************************
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			state <= '{cs_sync: 3'h7, sck_sync: 3'h0, si_sync: 2'h0, bit_count: 6'h00,
				shift: 32'h00000000, write_enable_latch: 1'b0, rdy_route: 1'b0, reset_armed: 1'b0,
				mode: SFEC_STANDBY, pd: 1'b0, timer: 18'h00000, start: 1'b0,
				kind: SFEC_ER_SECTOR, base: 24'h000000};
		end else begin
			state <= next_state;
		end
	end

	// outputs; serial output only drives when status routing is on
	assign write_enable_latch_out     = state.write_enable_latch;
	assign write_in_progress_flag_out = state.mode == SFEC_ERASING;
	assign deep_power_down_out        = state.pd;
	assign erase_start_out            = state.start;
	assign erase_kind_out             = state.kind;
	assign erase_base_out             = state.base;
	assign so_out                     = state.mode == SFEC_STANDBY && !other_cycle_busy_in;
	assign so_oe_out                  = state.rdy_route;

	// ****************************************
	// checks
	// ****************************************
	a_erase_needs_wel: assert property (@(posedge clk_in) disable iff (reset_in)
		$rose(write_in_progress_flag_out) |-> $past(state.write_enable_latch))
		else $error("erase started without write enable latch");
	a_wel_clears: assert property (@(posedge clk_in) disable iff (reset_in)
		write_in_progress_flag_out |=> !write_enable_latch_out)
		else $error("latch not cleared during erase");
	a_erase_at_rise: assert property (@(posedge clk_in) disable iff (reset_in)
		erase_start_out |-> $past(cs_rise) && write_in_progress_flag_out)
		else $error("erase start not at deselect");
	a_pd_not_busy: assert property (@(posedge clk_in) disable iff (reset_in)
		$rose(state.mode == SFEC_PD_ENTER) |->
		$past(state.mode == SFEC_STANDBY && !other_cycle_busy_in))
		else $error("power-down entered during a cycle");
	a_pd_blocks: assert property (@(posedge clk_in) disable iff (reset_in)
		state.pd && $past(state.pd) |-> !erase_start_out && !$rose(state.write_enable_latch))
		else $error("command acted in power-down");
	a_rdy_level: assert property (@(posedge clk_in) disable iff (reset_in)
		so_oe_out && write_in_progress_flag_out |-> !so_out)
		else $error("ready shown while erasing");
	a_base_aligned: assert property (@(posedge clk_in) disable iff (reset_in)
		erase_start_out && erase_kind_out == SFEC_ER_SECTOR |-> erase_base_out[11:0] == 12'h000)
		else $error("sector base not aligned");
	a_pd_entry_delay: assert property (@(posedge clk_in) disable iff (reset_in)
		$rose(state.mode == SFEC_PD_ENTER) |-> !state.pd [*8])
		else $error("power-down entered too soon");
	// one-byte erase needs exactly 8 bits, addressed erase exactly 32
	a_erase_bit_count: assert property (@(posedge clk_in) disable iff (reset_in)
		erase_start_out |-> $past(state.bit_count) == (erase_kind_out == SFEC_ER_ARRAY ?
		`SFEC_OPCODE_BITS : `SFEC_ADDR_CMD_BITS))
		else $error("erase accepted at wrong bit count");
	a_array_protect: assert property (@(posedge clk_in) disable iff (reset_in)
		erase_start_out && erase_kind_out == SFEC_ER_ARRAY |->
		$past((block_protect_field_in[2:0] == 3'h0 && !protect_complement_bit_in) ||
		(block_protect_field_in[2:0] == 3'h7 && protect_complement_bit_in)))
		else $error("array erase under partial protection");
	a_pd_only_entry: assert property (@(posedge clk_in) disable iff (reset_in)
		$rose(state.pd) |-> $past(state.mode) == SFEC_PD_ENTER)
		else $error("power-down entered without its command");
	a_pd_exit_release: assert property (@(posedge clk_in) disable iff (reset_in)
		$rose(state.mode == SFEC_PD_EXIT) |-> $past(state.pd && op_now == `SFEC_OP_RELEASE_PD))
		else $error("power-down left without release");
	c_sector_erase: cover property (@(posedge clk_in) disable iff (reset_in)
		erase_start_out && erase_kind_out == SFEC_ER_SECTOR);
	c_array_erase: cover property (@(posedge clk_in) disable iff (reset_in)
		erase_start_out && erase_kind_out == SFEC_ER_ARRAY);
	c_pd_enter: cover property (@(posedge clk_in) disable iff (reset_in) $rose(state.pd));
	c_pd_exit: cover property (@(posedge clk_in) disable iff (reset_in) $fell(state.pd));
	c_block_erase: cover property (@(posedge clk_in) disable iff (reset_in)
		erase_start_out && erase_kind_out inside {SFEC_ER_BLK32, SFEC_ER_BLK64});
endmodule

// *** sfec_host.sv ***
// host-side serial controller model: drives select, link clock and data
// assumes the bench calls send() from one process at a time
`timescale 1ns/1ps

module sfec_host (
	// link pins
	output logic cs_n_out,
	output logic sck_out,
	output logic si_out
);
	// idle link: deselected, clock parked low
	initial begin
		cs_n_out = 1'b1;
		sck_out  = 1'b0;
		si_out   = 1'b0;
	end

	// clock only toggles inside a frame; 64 ns period
	task automatic send(input logic [39:0] vec, input int n);
		cs_n_out = 1'b0;
		for (int i = 39; i > 39 - n; i--) begin
			si_out = vec[i];
			#32 sck_out = 1'b1;
			#32 sck_out = 1'b0;
		end
		#16 cs_n_out = 1'b1;
		si_out = ~si_out; // released data never looks stable
	endtask
endmodule

// *** tb_top.sv ***
// self-checking bench for the erase and power-down command interpreter
// assumes sfec_host drives the link and a 200 MHz core clock
`timescale 1ns/1ps
`include "sfec_defines.svh"

module tb_top;
	import sfec_pkg::*;

	// ****************************************
	// signals and reference model state
	// ****************************************
	localparam logic [23:0] MASK [4] = '{24'hfff000, 24'hff8000, 24'hff0000, 24'h0};
	logic        clk_in, reset_in, cs_n, sck, si, so_out, so_oe_out;
	logic [4:0]  bp;
	logic        cmp, write_enable_latch, write_in_progress_flag, pd, start, obusy;
	sfec_erase_t kind;
	logic [23:0] base;
	logic [7:0]  ops [5];
	int          n_mismatch, comparisons;
	bit          m_wel, m_pd, m_route, m_busy;
	logic [25:0] exp_q [$];

	// long erase so a power-down frame fits inside one
	sfec_cmd #(.SECTOR_ERASE_CYC(300), .ARRAY_ERASE_CYC(400)) u_sfec_cmd (
		.clk_in(clk_in), .reset_in(reset_in), .cs_n_in(cs_n), .sck_in(sck), .si_in(si),
		.so_out(so_out), .so_oe_out(so_oe_out), .block_protect_field_in(bp),
		.protect_complement_bit_in(cmp), .other_cycle_busy_in(obusy),
		.write_enable_latch_out(write_enable_latch), .write_in_progress_flag_out(write_in_progress_flag),
		.deep_power_down_out(pd), .erase_start_out(start), .erase_kind_out(kind),
		.erase_base_out(base));
	sfec_host u_sfec_host (.cs_n_out(cs_n), .sck_out(sck), .si_out(si));

	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	task automatic chk(input logic [25:0] got, input logic [25:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// every accepted erase must match the oldest predicted one
	always @(negedge clk_in) begin
		if (start === 1'b1) begin
			if (exp_q.size() == 0)
				chk(26'h1, 26'h0, "unexpected erase");
			else
				chk({kind, base}, exp_q.pop_front(), "erase");
		end
	end

	// model predicts outcome, host sends the frame, then status is compared
	task automatic issue(input logic [7:0] op, input logic [23:0] a, input int n);
		bit prot, full, ok, ad, ar;
		sfec_erase_t k;
		prot = cmp ? (bp[2:0] == 3'h0) : (bp[2:0] == 3'h7);
		full = (bp[2:0] == 3'h0 && !cmp) || (bp[2:0] == 3'h7 && cmp);
		ad = op inside {`SFEC_OP_SECTOR_ERASE, `SFEC_OP_BLOCK32_ERASE, `SFEC_OP_BLOCK64_ERASE};
		ar = op inside {`SFEC_OP_ARRAY_ERASE_A, `SFEC_OP_ARRAY_ERASE_B};
		k = (op == `SFEC_OP_SECTOR_ERASE) ? SFEC_ER_SECTOR :
			(op == `SFEC_OP_BLOCK32_ERASE) ? SFEC_ER_BLK32 :
			(op == `SFEC_OP_BLOCK64_ERASE) ? SFEC_ER_BLK64 : SFEC_ER_ARRAY;
		ok = m_wel && !m_pd && !m_busy && !obusy;
		if ((ad && n == 32 && ok && !prot) || (ar && n == 8 && ok && full)) begin
			exp_q.push_back({k, a & MASK[k]});
			m_wel = 1'b0;
			m_busy = 1'b1;
		end
		if (n == 8 && !m_pd && !m_busy && !obusy && op == `SFEC_OP_WRITE_ENABLE)
			m_wel = 1'b1;
		if (n == 8 && !m_pd && op inside {`SFEC_OP_RDY_ENABLE, `SFEC_OP_RDY_DISABLE})
			m_route = (op == `SFEC_OP_RDY_ENABLE);
		if (n == 8 && op == `SFEC_OP_POWER_DOWN && !m_busy && !obusy)
			m_pd = 1'b1;
		if (n == 8 && op == `SFEC_OP_RELEASE_PD)
			m_pd = 1'b0;
		@(negedge clk_in);
		u_sfec_host.send({op, a, 8'h00}, n);
		repeat (12) @(negedge clk_in);
		chk(write_enable_latch, m_wel, "write enable latch");
		chk(write_in_progress_flag, m_busy, "in progress");
		chk(so_oe_out, m_route, "ready/busy route");
		if (m_route)
			chk(so_out, !m_busy && !obusy, "ready/busy level");
	endtask

	task automatic wait_idle();
		int i;
		for (i = 0; i < 2000 && write_in_progress_flag !== 1'b0; i++)
			@(negedge clk_in);
		if (i == 2000) begin
			n_mismatch++;
			end_of_test();
		end
		m_busy = 1'b0;
		chk(26'(exp_q.size()), 26'h0, "erase missing");
		if (m_route)
			chk(so_out, 1'b1, "ready level");
	endtask

	// power state changes only after its long entry or release delay
	task automatic wait_pd(input bit want);
		int i;
		for (i = 0; i < 800 && pd !== want; i++)
			@(negedge clk_in);
		if (i == 800) begin
			n_mismatch++;
			end_of_test();
		end
		chk(i > 500, 1'b1, "power state delay");
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		ops = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
		reset_in = 1'b1;
		bp = 5'h0;
		cmp = 1'b0;
		obusy = 1'b0;
		void'($urandom(20283));
		repeat (2) @(posedge clk_in);
		@(negedge clk_in) reset_in = 1'b0;
		chk({write_enable_latch, write_in_progress_flag, pd, start, so_oe_out}, 26'h0, "reset state");
		issue(`SFEC_OP_RDY_ENABLE, 24'h0, 9);
		issue(`SFEC_OP_RDY_ENABLE, 24'h0, 8);
		$display("test ready_busy done");
		foreach (ops[j]) begin
			issue(`SFEC_OP_WRITE_ENABLE, 24'h0, 8);
			issue(ops[j], 24'($urandom), (j > 2) ? 8 : 32);
			wait_idle();
		end
		$display("test erase_kinds done");
		issue(`SFEC_OP_SECTOR_ERASE, 24'($urandom), 32);
		issue(`SFEC_OP_WRITE_ENABLE, 24'h0, 8);
		issue(`SFEC_OP_BLOCK64_ERASE, 24'($urandom), 31);
		issue(`SFEC_OP_BLOCK32_ERASE, 24'($urandom), 33);
		bp = 5'h07;
		issue(`SFEC_OP_SECTOR_ERASE, 24'($urandom), 32);
		issue(`SFEC_OP_ARRAY_ERASE_A, 24'h0, 8);
		cmp = 1'b1;
		issue(`SFEC_OP_ARRAY_ERASE_B, 24'h0, 8);
		wait_idle();
		bp = 5'h0;
		cmp = 1'b0;
		issue(`SFEC_OP_RDY_DISABLE, 24'h0, 8);
		$display("test refusals done");
		issue(`SFEC_OP_WRITE_ENABLE, 24'h0, 8);
		issue(`SFEC_OP_SECTOR_ERASE, 24'($urandom), 32);
		issue(`SFEC_OP_POWER_DOWN, 24'h0, 8);
		wait_idle();
		// a cycle running elsewhere blocks power-down too; wait past the entry delay
		obusy = 1'b1;
		issue(`SFEC_OP_POWER_DOWN, 24'h0, 8);
		repeat (620) @(negedge clk_in);
		obusy = 1'b0;
		chk(pd, 1'b0, "power-down while busy");
		issue(`SFEC_OP_POWER_DOWN, 24'h0, 8);
		wait_pd(1'b1);
		issue(`SFEC_OP_WRITE_ENABLE, 24'h0, 8);
		issue(`SFEC_OP_SECTOR_ERASE, 24'($urandom), 32);
		issue(`SFEC_OP_RELEASE_PD, 24'h0, 8);
		wait_pd(1'b0);
		repeat (620) @(negedge clk_in);
		issue(`SFEC_OP_WRITE_ENABLE, 24'h0, 8);
		$display("test power_down done");
		end_of_test();
	end
endmodule
